// ### rtl/fbss_pkg.sv
// fbss_pkg: register map, field layout and widths for the buffer swap block
// assumes an apb slave with 32-bit data and word-aligned registers
package fbss_pkg;
	localparam int unsigned FBSS_AW = 16;
	localparam logic [15:0] FBSS_OFS_START_ROW = 16'h3068;
	localparam logic [15:0] FBSS_OFS_ROW_LEN = 16'h3000;
	localparam logic [15:0] FBSS_OFS_SCANLINE = 16'h3004;
	localparam logic [15:0] FBSS_OFS_INT_STAT = 16'h3008;
	localparam logic [15:0] FBSS_OFS_INT_MASK = 16'h300c;
	localparam logic [15:0] FBSS_OFS_STATUS = 16'h3010;
	localparam int unsigned FBSS_ROW_W = 12;
	localparam int unsigned FBSS_LEN_W = 14;
	localparam int unsigned FBSS_ADR_W = 24;
	localparam int unsigned FBSS_LINE_W = 12;
	localparam logic [13:0] FBSS_ROW_LEN_RST = 14'h0800;
	localparam logic [11:0] FBSS_LINE_RST = 12'h001;
	localparam int unsigned FBSS_INT_VBLANK = 0;
	localparam int unsigned FBSS_INT_SWAP = 1;
	localparam int unsigned FBSS_NINT = 2;
	localparam int unsigned FBSS_ST_PEND = 0;
	localparam int unsigned FBSS_ST_BLOCK = 1;
	localparam int unsigned FBSS_ST_SWAP_RD = 2;
	localparam logic [1:0] FBSS_CMD_NONE = 2'h0;
	localparam logic [1:0] FBSS_CMD_OFFSET = 2'h1;
	localparam logic [1:0] FBSS_CMD_SWAP = 2'h2;
	localparam logic [1:0] FBSS_CMD_OTHER = 2'h3;
	localparam int unsigned FBSS_SWAP_ROW_LSB = 0;
	localparam int unsigned FBSS_SWAP_RAMDAC_BIT = 31;
	typedef enum logic [1:0] {
		FBSS_IDLE = 2'b00,
		FBSS_FLUSH = 2'b01,
		FBSS_WAIT = 2'b10
	} fbss_swap_e;
endpackage

// ### rtl/fbss_addr_add.sv
// fbss_addr_add: registered final pixel address adder
// assumes pixel address and offset are valid together with pix_valid
`timescale 1ns/1ns
module fbss_addr_add
	import fbss_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic pix_valid,
	input wire logic [FBSS_ADR_W-1:0] pix_addr,
	input wire logic [FBSS_ADR_W-1:0] pix_offset,
	output logic fb_valid,
	output logic [FBSS_ADR_W-1:0] fb_addr
);
	typedef struct packed {
		logic v;
		logic [FBSS_ADR_W-1:0] a;
	} fbss_add_s;
	fbss_add_s s_q, s_d;
	always_comb begin
		s_d.v = pix_valid;
		s_d.a = pix_valid ? pix_addr + pix_offset : s_q.a; // [R1]
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign fb_valid = s_q.v;
	assign fb_addr = s_q.a;
	a_add_sum: assert property (@(posedge clk) disable iff (!rst_b)
		pix_valid |=> fb_addr == $past(pix_addr) + $past(pix_offset)) // [R1]
		else $error("pixel offset not added");
endmodule

// ### rtl/fbss_top.sv
// fbss_top: buffer swap sync, display start row, scanline counter, vblank irq
// assumes commands arrive in fifo order on cmd_* and video timing on line_start/vblank
//
// Contract
// R1 - add render offset to every framebuffer address
// R2 - sample start row at end of blanking
// R3 - offset load acts at fifo exit
// R4 - host start row writes bypass fifo
// R5 - swap command flushes then blocks framebuffer
// R6 - swap data loads start row or ramdac
// R7 - non-framebuffer commands continue while waiting (code: not while a framebuffer command is parked)
// R8 - framebuffer command stalls while swap pending
// R9 - scanline counter one at blank, increments
// R10 - host polls scanline below small threshold
// R11 - vertical blank interrupt provided
// R12 - host swaps only after rendering finished
// R13 - start row times row length gives scan address
// R14 - start row register at 0x3068
// R15 - release block after swap, fifo order kept
`timescale 1ns/1ns
module fbss_top
	import fbss_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [FBSS_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cmd_valid,
	input wire logic [1:0] cmd_kind,
	input wire logic cmd_fb,
	input wire logic [31:0] cmd_data,
	output logic cmd_ready,
	input wire logic fb_idle,
	input wire logic pix_valid,
	input wire logic [FBSS_ADR_W-1:0] pix_addr,
	output logic fb_valid,
	output logic [FBSS_ADR_W-1:0] fb_addr,
	output logic fb_block,
	input wire logic line_start,
	input wire logic vblank,
	output logic [FBSS_ADR_W-1:0] scan_base,
	output logic ramdac_swap,
	output logic [31:0] ramdac_data,
	output logic irq
);
	typedef struct packed {
		fbss_swap_e st;
		logic [FBSS_ROW_W-1:0] start_row;
		logic [FBSS_LEN_W-1:0] row_len;
		logic [FBSS_ADR_W-1:0] pix_off;
		logic [FBSS_ADR_W-1:0] base;
		logic [FBSS_LINE_W-1:0] line;
		logic [31:0] swap_data;
		logic vblank_q;
		logic [FBSS_NINT-1:0] int_st;
		logic [FBSS_NINT-1:0] int_mask;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic cready;
		logic block;
		logic rd_swap;
		logic [31:0] rd_data;
		logic irq;
		logic held_v;
		logic [1:0] held_kind;
		logic [31:0] held_data;
	} fbss_top_s;
	fbss_top_s s_q, s_d;

	function automatic logic is_map(input logic [FBSS_AW-1:0] a);
		is_map = (a == FBSS_OFS_START_ROW) || (a == FBSS_OFS_ROW_LEN) ||
			(a == FBSS_OFS_SCANLINE) || (a == FBSS_OFS_INT_STAT) ||
			(a == FBSS_OFS_INT_MASK) || (a == FBSS_OFS_STATUS);
	endfunction

	logic setup;
	logic acc;
	logic pend;
	logic park;
	logic exe_v;
	logic [1:0] exe_kind;
	logic [31:0] exe_data;
	logic [FBSS_NINT-1:0] int_nx;
	logic wr;
	logic vb_end;
	logic vb_rise;
	logic cmd_take;
	logic fb_cmd;
	logic [FBSS_NINT-1:0] ev;
	logic [FBSS_ADR_W-1:0] prod;
	// first access-phase cycle: registers the answer, pready follows
	assign setup = psel && penable && !s_q.ready;
	// access edge with pready high: writes land here
	assign acc = psel && penable && s_q.ready;
	assign wr = acc && pwrite;
	assign pend = s_q.st != FBSS_IDLE;
	assign vb_end = s_q.vblank_q && !vblank;
	assign vb_rise = vblank && !s_q.vblank_q;
	// framebuffer commands include offset loads so they stay in order with rendering
	assign fb_cmd = cmd_fb || (cmd_kind == FBSS_CMD_SWAP) || (cmd_kind == FBSS_CMD_OFFSET);
	assign prod = FBSS_ADR_W'(s_q.start_row) * FBSS_ADR_W'(s_q.row_len);

	// one sticky bit per event; set wins over a same-cycle clear
	for (genvar i = 0; i < FBSS_NINT; i++) begin : g_int
		assign int_nx[i] = ev[i] ||
			(s_q.int_st[i] && !(wr && paddr == FBSS_OFS_INT_STAT && pwdata[i])); // [R11]
	end

	always_comb begin
		s_d = s_q;
		ev = '0;
		s_d.vblank_q = vblank;
		s_d.ready = setup;
		s_d.err = setup && !is_map(paddr);
		s_d.rd_swap = 1'b0;
		cmd_take = cmd_valid && s_q.cready;
		// fb commands that meet a pending swap park in the hold slot
		park = cmd_take && fb_cmd && (pend || s_q.held_v); // [R8]
		exe_v = 1'b0;
		exe_kind = FBSS_CMD_NONE;
		exe_data = '0;
		if (park) begin
			s_d.held_v = 1'b1; // [R8]
			s_d.held_kind = cmd_kind;
			s_d.held_data = cmd_data;
		end else if (cmd_take) begin
			exe_v = 1'b1;
			exe_kind = cmd_kind;
			exe_data = cmd_data;
		end else if (s_q.held_v && !pend) begin
			// swap done: the parked command runs first, order kept
			exe_v = 1'b1; // [R15]
			exe_kind = s_q.held_kind;
			exe_data = s_q.held_data;
			s_d.held_v = 1'b0; // [R15]
		end
		if (exe_v) begin
			case (exe_kind)
				FBSS_CMD_OFFSET: s_d.pix_off = exe_data[FBSS_ADR_W-1:0]; // [R3]
				FBSS_CMD_SWAP: begin
					s_d.swap_data = exe_data; // [R6]
					s_d.st = FBSS_FLUSH; // [R5]
				end
				default: s_d.st = s_q.st;
			endcase
		end
		case (s_q.st)
			FBSS_IDLE: s_d.block = 1'b0;
			FBSS_FLUSH: begin
				if (fb_idle) begin
					s_d.st = FBSS_WAIT; // [R5]
					s_d.block = 1'b1; // [R5]
				end
			end
			FBSS_WAIT: begin
				if (vb_rise) begin
					if (s_q.swap_data[FBSS_SWAP_RAMDAC_BIT]) begin
						s_d.rd_swap = 1'b1; // [R6]
						s_d.rd_data = s_q.swap_data;
					end else begin
						s_d.start_row = s_q.swap_data[FBSS_SWAP_ROW_LSB+:FBSS_ROW_W]; // [R6]
					end
					s_d.st = FBSS_IDLE; // [R15]
					s_d.block = 1'b0; // [R15]
					ev[FBSS_INT_SWAP] = 1'b1;
				end
			end
			default: s_d.st = FBSS_IDLE;
		endcase
		// registered ready: low only while a command sits in the hold slot
		s_d.cready = !s_d.held_v; // [R7] [R8]
		if (vb_end) begin
			s_d.base = prod; // [R2] [R13]
		end
		if (vb_rise) begin
			s_d.line = FBSS_LINE_RST; // [R9]
			ev[FBSS_INT_VBLANK] = 1'b1; // [R11]
		end else if (line_start && s_q.line != '1) begin
			s_d.line = s_q.line + 1'b1; // [R9]
		end
		if (wr) begin
			case (paddr)
				FBSS_OFS_START_ROW: s_d.start_row = pwdata[FBSS_ROW_W-1:0]; // [R4] [R14]
				FBSS_OFS_ROW_LEN: s_d.row_len = pwdata[FBSS_LEN_W-1:0];
				FBSS_OFS_INT_MASK: s_d.int_mask = pwdata[FBSS_NINT-1:0];
				default: s_d.int_mask = s_d.int_mask;
			endcase
		end
		s_d.int_st = int_nx;
		s_d.rdata = '0;
		if (setup && !pwrite) begin
			case (paddr)
				FBSS_OFS_START_ROW: s_d.rdata = 32'(s_q.start_row);
				FBSS_OFS_ROW_LEN: s_d.rdata = 32'(s_q.row_len);
				FBSS_OFS_SCANLINE: s_d.rdata = 32'(s_q.line);
				FBSS_OFS_INT_STAT: s_d.rdata = 32'(s_q.int_st);
				FBSS_OFS_INT_MASK: s_d.rdata = 32'(s_q.int_mask);
				FBSS_OFS_STATUS: begin
					s_d.rdata[FBSS_ST_PEND] = s_q.st != FBSS_IDLE;
					s_d.rdata[FBSS_ST_BLOCK] = s_q.block;
				end
				default: s_d.rdata = '0;
			endcase
		end
		s_d.irq = |(s_d.int_st & s_d.int_mask); // [R11]
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
			s_q.st <= FBSS_IDLE;
			s_q.row_len <= FBSS_ROW_LEN_RST;
			s_q.line <= FBSS_LINE_RST;
			s_q.cready <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	fbss_addr_add u_add (
		.clk(clk),
		.rst_b(rst_b),
		.pix_valid(pix_valid),
		.pix_addr(pix_addr),
		.pix_offset(s_q.pix_off),
		.fb_valid(fb_valid),
		.fb_addr(fb_addr)
	);

	assign prdata = s_q.rdata;
	assign pready = s_q.ready;
	assign pslverr = s_q.err;
	assign cmd_ready = s_q.cready;
	assign fb_block = s_q.block;
	assign scan_base = s_q.base;
	assign ramdac_swap = s_q.rd_swap;
	assign ramdac_data = s_q.rd_data;
	assign irq = s_q.irq;

	a_base_end: assert property (@(posedge clk) disable iff (!rst_b)
		vb_end |=> scan_base == FBSS_ADR_W'($past(s_q.start_row)) * FBSS_ADR_W'($past(s_q.row_len))) // [R2]
		else $error("scan base not sampled at blank end");
	a_base_hold: assert property (@(posedge clk) disable iff (!rst_b)
		!vb_end |=> $stable(scan_base)) // [R13]
		else $error("scan base changed outside blank end");
	a_row_direct: assert property (@(posedge clk) disable iff (!rst_b)
		wr && paddr == FBSS_OFS_START_ROW && !(s_q.st == FBSS_WAIT && vb_rise)
		|=> s_q.start_row == $past(pwdata[FBSS_ROW_W-1:0])) // [R4]
		else $error("start row write lost");
	a_off_load: assert property (@(posedge clk) disable iff (!rst_b)
		cmd_take && cmd_kind == FBSS_CMD_OFFSET
		|=> s_q.pix_off == $past(cmd_data[FBSS_ADR_W-1:0])) // [R3]
		else $error("offset not loaded at fifo exit");
	a_flush_block: assert property (@(posedge clk) disable iff (!rst_b)
		s_q.st == FBSS_FLUSH && fb_idle |=> fb_block && s_q.st == FBSS_WAIT) // [R5]
		else $error("block not raised after flush");
	a_fb_stall: assert property (@(posedge clk) disable iff (!rst_b)
		pend && cmd_take && fb_cmd |=> s_q.held_v && !cmd_ready) // [R8]
		else $error("framebuffer command not stalled while swap pending");
	a_held_wait: assert property (@(posedge clk) disable iff (!rst_b)
		s_q.held_v && pend |=> s_q.held_v) // [R8]
		else $error("parked command ran before swap");
	a_held_go: assert property (@(posedge clk) disable iff (!rst_b)
		s_q.held_v && !pend |=> !s_q.held_v) // [R15]
		else $error("parked command not resumed");
	a_cready_held: assert property (@(posedge clk) disable iff (!rst_b)
		s_q.held_v |-> !cmd_ready) // [R8]
		else $error("fifo accepted behind parked command");
	a_off_park: assert property (@(posedge clk) disable iff (!rst_b)
		park && cmd_kind == FBSS_CMD_OFFSET
		|=> s_q.pix_off == $past(s_q.pix_off)) // [R3]
		else $error("parked offset applied early");
	a_flush_wait: assert property (@(posedge clk) disable iff (!rst_b)
		s_q.st == FBSS_FLUSH && !fb_idle |=> s_q.st == FBSS_FLUSH && !fb_block) // [R5]
		else $error("flush left before framebuffer idle");
	a_block_wait: assert property (@(posedge clk) disable iff (!rst_b)
		fb_block |-> s_q.st == FBSS_WAIT) // [R5]
		else $error("block outside swap wait");
	a_release: assert property (@(posedge clk) disable iff (!rst_b)
		s_q.st == FBSS_WAIT && vb_rise |=> !fb_block ##0 s_q.st == FBSS_IDLE) // [R15]
		else $error("block not released after swap");
	a_swap_row: assert property (@(posedge clk) disable iff (!rst_b)
		s_q.st == FBSS_WAIT && vb_rise && !s_q.swap_data[FBSS_SWAP_RAMDAC_BIT] && !wr
		|=> s_q.start_row == $past(s_q.swap_data[FBSS_ROW_W-1:0])) // [R6]
		else $error("swap did not load start row");
	a_dac_row: assert property (@(posedge clk) disable iff (!rst_b)
		s_q.st == FBSS_WAIT && vb_rise && s_q.swap_data[FBSS_SWAP_RAMDAC_BIT] && !wr
		|=> s_q.start_row == $past(s_q.start_row)) // [R6]
		else $error("ramdac swap touched start row");
	a_dac_pulse: assert property (@(posedge clk) disable iff (!rst_b)
		ramdac_swap |=> !ramdac_swap) // [R6]
		else $error("ramdac swap longer than one cycle");
	a_line_step: assert property (@(posedge clk) disable iff (!rst_b)
		line_start && !vb_rise && s_q.line != '1
		|=> s_q.line == $past(s_q.line) + 1'b1) // [R9]
		else $error("scanline did not advance");
	a_line_floor: assert property (@(posedge clk) disable iff (!rst_b)
		s_q.line != '0) // [R9]
		else $error("scanline below one");
	a_ready_one: assert property (@(posedge clk) disable iff (!rst_b)
		pready |=> !pready) // [R14]
		else $error("pready longer than one cycle");
	a_err_ready: assert property (@(posedge clk) disable iff (!rst_b)
		pslverr |-> pready) // [R14]
		else $error("pslverr without pready");
	a_swap_irq: assert property (@(posedge clk) disable iff (!rst_b)
		s_q.st == FBSS_WAIT && vb_rise |=> s_q.int_st[FBSS_INT_SWAP]) // [R11]
		else $error("swap done status not set");
	a_irq_level: assert property (@(posedge clk) disable iff (!rst_b)
		irq == |(s_q.int_st & s_q.int_mask)) // [R11]
		else $error("irq level wrong");
	a_line_one: assert property (@(posedge clk) disable iff (!rst_b)
		vb_rise |=> s_q.line == FBSS_LINE_RST ##0 s_q.line != '0) // [R9]
		else $error("scanline not one at blank");
	a_vb_irq: assert property (@(posedge clk) disable iff (!rst_b)
		vb_rise && s_q.int_mask[FBSS_INT_VBLANK] |=> s_q.int_st[FBSS_INT_VBLANK] && irq) // [R11]
		else $error("vblank interrupt missing");
	a_other_go: assert property (@(posedge clk) disable iff (!rst_b)
		s_q.st == FBSS_WAIT && !s_q.held_v |-> cmd_ready) // [R7]
		else $error("non-framebuffer command stalled");
endmodule

// ### bench/fbss_host_model.sv
// fbss_host_model: host driver that presents commands at the fifo head
// assumes the bench calls send after a rising edge
`timescale 1ns/1ns
module fbss_host_model (
	input wire logic clk,
	input wire logic cmd_ready,
	output logic cmd_valid,
	output logic [1:0] cmd_kind,
	output logic cmd_fb,
	output logic [31:0] cmd_data,
	output logic host_to
);
	initial begin
		cmd_valid = 1'b0;
		cmd_kind = 2'h0;
		cmd_fb = 1'b0;
		cmd_data = 32'h0;
		host_to = 1'b0;
	end
	// swaps are queued only after the frame's render commands
	task automatic send(input logic [1:0] k, input logic f, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_kind <= k;
		cmd_fb <= f;
		cmd_data <= d;
		do begin
			@(posedge clk);
			n++;
		end while (!cmd_ready && n < 400);
		if (!cmd_ready)
			host_to = 1'b1;
		cmd_valid <= 1'b0;
		// idle head shows no stale payload
		cmd_data <= ~d;
	endtask
endmodule

// ### bench/fbss_top_tb_top.sv
// fbss_top_tb_top: scenario bench for the buffer swap block
// assumes apb answers with pready and video timing comes from here
`timescale 1ns/1ns
module fbss_top_tb_top;
	import fbss_pkg::*;
	logic clk, rst_b, psel, penable, pwrite, pready, pslverr, cmd_valid, cmd_fb;
	logic cmd_ready, fb_idle, pix_valid, fb_valid, fb_block, line_start, vblank;
	logic ramdac_swap, irq, host_to, err;
	logic dac_seen = 1'b0;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, cmd_data, ramdac_data, rd;
	logic [1:0] cmd_kind;
	logic [23:0] pix_addr, fb_addr, scan_base;
	int err_total, checks, cyc;
	fbss_top u_dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .cmd_valid, .cmd_kind, .cmd_fb, .cmd_data, .cmd_ready, .fb_idle,
		.pix_valid, .pix_addr, .fb_valid, .fb_addr, .fb_block, .line_start, .vblank,
		.scan_base, .ramdac_swap, .ramdac_data, .irq);
	fbss_host_model u_host (.clk, .cmd_ready, .cmd_valid, .cmd_kind, .cmd_fb, .cmd_data,
		.host_to);
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (ramdac_swap === 1'b1)
			dac_seen <= 1'b1;
		if (cyc == 20000) begin
			err_total++;
			stop_test();
		end
	end
	task automatic stop_test();
		if (err_total == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic frame(input int lines);
		@(posedge clk);
		vblank <= 1'b1;
		repeat (3) @(posedge clk);
		vblank <= 1'b0;
		repeat (lines) begin
			@(posedge clk);
			line_start <= 1'b1;
			@(posedge clk);
			line_start <= 1'b0;
		end
		repeat (3) @(posedge clk);
	endtask
	task automatic pix(input logic [23:0] a, input logic [23:0] e);
		@(posedge clk);
		pix_valid <= 1'b1;
		pix_addr <= a;
		@(posedge clk);
		pix_valid <= 1'b0;
		#1 chk("fb_addr", e, fb_addr);
	endtask
	task automatic t_regs();
		apb(0, FBSS_OFS_ROW_LEN, 0);
		chk("row_len", FBSS_ROW_LEN_RST, rd);
		apb(0, FBSS_OFS_SCANLINE, 0);
		chk("scanline", FBSS_LINE_RST, rd);
		apb(0, 16'h3020, 0);
		chk("unmapped", 1, err);
	endtask
	task automatic t_row();
		apb(1, FBSS_OFS_ROW_LEN, 32'h10);
		apb(1, FBSS_OFS_START_ROW, 32'h5);
		apb(0, FBSS_OFS_START_ROW, 0);
		chk("start_row", 5, rd);
		chk("base_hold", 0, scan_base);
		frame(2);
		chk("base", 32'h50, scan_base);
		apb(0, FBSS_OFS_SCANLINE, 0);
		chk("scanline", 3, rd);
		chk("poll", 1, rd < 4);
		apb(1, FBSS_OFS_INT_MASK, 1);
		#1 chk("irq_on", 1, irq);
		apb(1, FBSS_OFS_INT_STAT, 1);
		#1 chk("irq_off", 0, irq);
	endtask
	task automatic t_pix();
		pix(24'h7, 24'h7);
		u_host.send(FBSS_CMD_OFFSET, 1'b1, 32'd100);
		pix(24'h7, 24'h6b);
	endtask
	task automatic t_swap();
		fb_idle <= 1'b0;
		u_host.send(FBSS_CMD_SWAP, 1'b1, 32'h9);
		repeat (4) @(posedge clk);
		#1 chk("flush", 0, fb_block);
		fb_idle <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk("block", 1, fb_block);
		u_host.send(FBSS_CMD_OTHER, 1'b0, 32'h0);
		chk("other", 0, host_to);
		fork
			begin
				u_host.send(FBSS_CMD_OTHER, 1'b1, 32'h0);
				u_host.send(FBSS_CMD_OFFSET, 1'b1, 32'h0);
			end
		join_none
		repeat (10) @(posedge clk);
		#1 chk("stall", 1, cmd_valid);
		apb(0, FBSS_OFS_STATUS, 0);
		chk("status", 3, rd);
		pix(24'h7, 24'h6b);
		frame(1);
		chk("unblock", 0, fb_block);
		chk("resume", 0, cmd_valid);
		pix(24'h7, 24'h7);
		chk("swap_row", 32'h90, scan_base);
		apb(0, FBSS_OFS_INT_STAT, 0);
		chk("swap_irq", 1, rd[FBSS_INT_SWAP]);
		u_host.send(FBSS_CMD_SWAP, 1'b1, 32'h8000_0007);
		frame(1);
		chk("dac", 1, dac_seen);
		chk("dac_data", 32'h8000_0007, ramdac_data);
		chk("dac_row", 32'h90, scan_base);
	endtask
	initial begin
		rst_b = 1'b0;
		{psel, penable, pwrite, pix_valid, line_start, vblank} = 6'h0;
		fb_idle = 1'b1;
		paddr = 16'h0;
		pwdata = 32'h0;
		pix_addr = 24'h0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		t_regs();
		t_row();
		t_pix();
		t_swap();
		chk("host", 0, host_to);
		stop_test();
	end
endmodule
